/* shared/flash_seq_defs.svh */
// Constants for the flash self-programming sequencer.
// Contract
// - Flash is programmed whole pages from the buffer; erase precedes write.
// - Erase code plus store-program within four cycles starts page erase; data ignored.
// - Erase takes its page only from the page index field.
// - Erasing a stalling-section page halts the CPU; else stalling section stays readable.
// - Load code plus store-program stores the data pair at the word index.
// - Buffer clears after page write, on section read enable, and on reset.
// - Each buffer word accepts one load between buffer clears.
// - An EEPROM write during page loading discards all loaded buffer data.
// - Write code plus store-program copies the buffer into the indexed page.
// - Writing a stalling-section page halts the CPU; else stalling section stays readable.
// - With interrupt enabled, request is held while the enable bit is clear.
// - Concurrent-read section is blocked and busy flag set while programming it.
// - Busy flag clears by section read enable after programming completes; the code also clears it on a page load.
// - Lock-set programs each lock bit whose data bit, bits five to two, is zero.
// - Lock programming neither halts the CPU nor blocks any section.
// - During an EEPROM write all commands and readback requests are refused.
// - Pointer one with lock-set armed: load-program within three cycles returns lock bits.
// - Lock-set and enable self-clear on readback or on the three/four cycle timeouts; the code clears them on readback, a store or the four-cycle timeout.
// - Pointer zero with lock-set armed: load-program within three cycles returns low fuse.
// - Buffer words may be loaded in any order.
// - Undefined low-five command values are ignored and arm nothing.
// - Section read re-enable has no effect while erase or write runs.
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// --------------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------------
`define OFS_CONTROL      8'h00
`define OFS_POINTER      8'h04
`define OFS_DATA_PAIR    8'h08
`define OFS_ISSUE        8'h0c
`define OFS_RESULT       8'h10
`define OFS_LOCKS        8'h14
`define OFS_BUF_PEEK     8'h18

// --------------------------------------------------------------------------
// Control, issue and data-pair register bit positions
// --------------------------------------------------------------------------
`define BIT_IRQ_EN       7
`define BIT_BUSY_FLAG    6
`define BIT_LOCK_SET     3
`define BIT_ISSUE_STORE  0
`define BIT_ISSUE_LOAD   1
`define LOCK_LSB         2

// --------------------------------------------------------------------------
// Command codes in the low five control bits
// --------------------------------------------------------------------------
`define CMD_NONE         5'h00
`define CMD_LOAD         5'h01
`define CMD_ERASE        5'h03
`define CMD_WRITE        5'h05
`define CMD_LOCK         5'h09
`define CMD_REENABLE     5'h11

// --------------------------------------------------------------------------
// Reset values, timing and AXI response codes
// --------------------------------------------------------------------------
`define LOCKS_RESET      4'hf
`define FUSE_LOW_RESET   8'h62
`define STORE_WINDOW     3'h4
`define LOAD_WINDOW      3'h3
`define CLK_PERIOD_NS    25
`define PROG_TIME_NS     3700000
`define PROG_CYCLES      ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2

`endif

/* shared/flash_seq_pkg.sv */
// Types shared by the flash self-programming sequencer.
package flash_seq_pkg;
    typedef logic [4:0] cmd_t;
    typedef enum logic [1:0] {
        OP_ERASE,
        OP_WRITE,
        OP_LOCK
    } op_kind_t;
    typedef enum logic {
        PHASE_IDLE,
        PHASE_RUN
    } phase_t;
endpackage : flash_seq_pkg

/* sim/eeprom_write_model.sv */
// Processor-side EEPROM writer that holds its busy flag for a fixed time.
module eeprom_write_model #(
    parameter int BUSY_CYCLES = 8
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic startWrite,
    output logic      eepromWriteBusy
);
    int remaining;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            remaining <= 0;
        end else if (startWrite) begin
            remaining <= BUSY_CYCLES;
        end else if (remaining > 0) begin
            remaining <= remaining - 1;
        end
    end
    // Busy stays up the whole write, so any overlap with a load is seen.
    assign eepromWriteBusy = (remaining > 0);
endmodule : eeprom_write_model

/* sim/flash_self_program_sequencer_tb.sv */
// Self-checking bench for the flash self-programming sequencer.
`include "flash_seq_defs.svh"
module flash_self_program_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_seq_pkg::*;
    logic        clk_sys, nrst, awvalid, wvalid, bready, arvalid, rready, eeGo, eeBusy;
    logic        awready, wready, bvalid, arready, rvalid, cpuHalt, sectionBlocked, readyIrq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rdVal;
    logic [3:0]  wstrb;
    logic [1:0]  rresp, rdResp, bresp;
    logic [9:0]  flashPage;
    op_kind_t    flashOpKind;
    int          bad_count, checks_done;
    flash_self_program_sequencer #(.OP_CYCLES(20)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .eepromWriteBusy(eeBusy),
        .cpuHalt(cpuHalt), .sectionBlocked(sectionBlocked), .readyIrq(readyIrq), .flashStart(),
        .flashOpKind(flashOpKind), .flashPage(flashPage));
    eeprom_write_model u_ee (.clk_sys(clk_sys), .nrst(nrst), .startWrite(eeGo), .eepromWriteBusy(eeBusy));
    // ----------------------------------------------------------------------
    // Bus and checking tasks
    // ----------------------------------------------------------------------
    task automatic test_done(input bit hung);
        if (hung) bad_count++;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Ready lines are raised one edge late so no signal is driven twice at an edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk_sys);
            if (bvalid) break;
            bready <= 1'b1;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (n == 60) test_done(1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk_sys);
            if (rvalid) break;
            rready <= 1'b1;
            if (arready) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        rdVal = rdata;
        rdResp = rresp;
        if (n == 60) test_done(1'b1);
        if (mask != 0) check(rdVal & mask, exp);
    endtask : rd
    task automatic spm(input logic [7:0] c, input logic [1:0] issue);
        wr(8'h00, {24'h0, c});
        wr(8'h0c, {30'h0, issue});
    endtask : spm
    task automatic wait_idle();
        rdVal = 32'h1;
        for (int n = 0; n < 40 && rdVal[0]; n++) rd(8'h00, 32'h0, 32'h0);
        if (rdVal[0]) test_done(1'b1);
    endtask : wait_idle
    // ----------------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready, eeGo} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(8'h00, 32'h0, 32'hff);
        rd(8'h14, 32'hff, 32'hff);
        rd(8'h40, 32'h0, 32'h0);
        check({30'h0, rdResp}, {30'h0, `AXI_SLVERR});
        wr(8'h40, 32'h0);
        check({30'h0, bresp}, {30'h0, `AXI_SLVERR});
        wr(8'h04, 32'h6);
        wr(8'h08, 32'h1234);
        spm({3'h0, `CMD_LOAD}, 2'h1);
        wr(8'h04, 32'h2);
        wr(8'h08, 32'habcd);
        spm({3'h0, `CMD_LOAD}, 2'h1);
        wr(8'h04, 32'h6);
        wr(8'h08, 32'h5555);
        spm({3'h0, `CMD_LOAD}, 2'h1);
        rd(8'h18, 32'h11234, 32'h1ffff);
        wr(8'h04, 32'h2);
        rd(8'h18, 32'h1abcd, 32'h1ffff);
        wr(8'h00, {27'h0, `CMD_LOAD});
        eeGo <= 1'b1;
        @(posedge clk_sys);
        eeGo <= 1'b0;
        spm({3'h0, `CMD_LOAD}, 2'h1);
        rd(8'h00, 32'h0, 32'h1f);
        rd(8'h18, 32'h0abcd, 32'h1ffff);
        spm(8'h07, 2'h1);
        rd(8'h00, 32'h0, 32'h1f);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'hcf);
        spm({3'h0, `CMD_LOCK}, 2'h1);
        wait_idle();
        rd(8'h14, 32'hcf, 32'hff);
        spm({3'h0, `CMD_LOCK}, 2'h2);
        rd(8'h10, 32'h1cf, 32'h1ff);
        wr(8'h04, 32'h0);
        spm({3'h0, `CMD_LOCK}, 2'h2);
        rd(8'h10, {23'h0, 1'b1, `FUSE_LOW_RESET}, 32'h1ff);
        wr(8'h00, {27'h0, `CMD_LOCK});
        repeat (5) @(posedge clk_sys);
        rd(8'h00, 32'h0, 32'h1f);
        wr(8'h04, 32'h14a);
        spm({3'h0, `CMD_ERASE}, 2'h1);
        check({22'h0, flashPage}, 32'h5);
        wr(8'h00, {27'h0, `CMD_REENABLE});
        rd(8'h00, 32'h41, 32'h5f);
        check({31'h0, sectionBlocked}, 32'h1);
        wait_idle();
        rd(8'h00, 32'h40, 32'h41);
        spm({3'h0, `CMD_REENABLE}, 2'h1);
        rd(8'h00, 32'h0, 32'h41);
        wr(8'h04, 32'h146);
        wr(8'h08, 32'h77);
        spm({3'h0, `CMD_LOAD}, 2'h1);
        wr(8'h04, 32'h140);
        spm({3'h0, `CMD_WRITE}, 2'h1);
        check({30'h0, flashOpKind}, {30'h0, OP_WRITE});
        wait_idle();
        wr(8'h04, 32'h146);
        rd(8'h18, 32'h00077, 32'h1ffff);
        wr(8'h04, 32'he000);
        spm({3'h4, `CMD_ERASE}, 2'h1);
        check({31'h0, cpuHalt}, 32'h1);
        check({31'h0, readyIrq}, 32'h0);
        wait_idle();
        @(posedge clk_sys);
        check({31'h0, readyIrq}, 32'h1);
        test_done(1'b0);
    end
endmodule : flash_self_program_sequencer_tb

/* sim/flash_seq_checker.sv */
// Concurrent checks on the sequencer's flash-side outputs.
module flash_seq_checker #(
    parameter int STALL_FIRST = 896,
    parameter int PAGE_BITS   = 10
) (
    input wire logic                    clk_sys,
    input wire logic                    nrst,
    input wire logic                    eepromWriteBusy,
    input wire logic                    cpuHalt,
    input wire logic                    sectionBlocked,
    input wire logic                    readyIrq,
    input wire logic                    flashStart,
    input wire flash_seq_pkg::op_kind_t flashOpKind,
    input wire logic [PAGE_BITS-1:0]    flashPage
);
    import flash_seq_pkg::*;
    // ----------------------------------------------------------------------
    // Operation classes
    // ----------------------------------------------------------------------
    wire stallOp = flashStart && flashOpKind != OP_LOCK && flashPage >= STALL_FIRST;
    wire rwwOp   = flashStart && flashOpKind != OP_LOCK && flashPage < STALL_FIRST;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    stall_halt_a: assert property (stallOp |-> ##[0:2] cpuHalt)
        else $error("stalling page op did not halt");
    no_halt_a: assert property (flashStart && !stallOp |=> !cpuHalt[*4])
        else $error("halt during non-stalling op");
    rww_block_a: assert property (rwwOp |-> ##[0:2] sectionBlocked)
        else $error("section not blocked");
    block_hold_a: assert property ($rose(sectionBlocked) |-> sectionBlocked[*8])
        else $error("block released early");
    op_length_a: assert property (flashStart |=> !flashStart[*8])
        else $error("op restarted too soon");
    halt_length_a: assert property ($fell(cpuHalt) |-> $past(cpuHalt, 8))
        else $error("halt too short");
    ee_refuse_a: assert property ($past(eepromWriteBusy) && eepromWriteBusy |-> !flashStart)
        else $error("op started during eeprom write");
    irq_quiet_a: assert property ($past(cpuHalt) && cpuHalt |-> !readyIrq)
        else $error("irq while busy");
endmodule : flash_seq_checker

bind flash_self_program_sequencer flash_seq_checker #(.STALL_FIRST(STALL_FIRST), .PAGE_BITS(PAGE_BITS)) u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .eepromWriteBusy(eepromWriteBusy), .cpuHalt(cpuHalt),
    .sectionBlocked(sectionBlocked), .readyIrq(readyIrq), .flashStart(flashStart),
    .flashOpKind(flashOpKind), .flashPage(flashPage));

/* verilog/flash_self_program_sequencer.sv */
// Flash self-programming sequencer with an AXI4-Lite register port.
`include "flash_seq_defs.svh"

module flash_self_program_sequencer #(
    parameter int          WORD_BITS   = 5,
    parameter int          PAGE_BITS   = 10,
    parameter int          STALL_FIRST = 896,
    parameter int          OP_CYCLES   = `PROG_CYCLES,
    parameter logic [7:0]  FUSE_LOW    = `FUSE_LOW_RESET
) (
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    input  wire logic [7:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [7:0]                 s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       eepromWriteBusy,
    output logic                            cpuHalt,
    output logic                            sectionBlocked,
    output logic                            readyIrq,
    output logic                            flashStart,
    output flash_seq_pkg::op_kind_t         flashOpKind,
    output logic [PAGE_BITS-1:0]            flashPage
);
    import flash_seq_pkg::*;

    localparam int WORDS = 1 << WORD_BITS;

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    logic                   awHeld;
    logic                   wHeld;
    logic [7:0]             awAddr;
    logic [31:0]            wData;
    logic [3:0]             wStrb;
    logic                   irqEnable;
    logic                   busyFlag;
    cmd_t                   armedCmd;
    logic [2:0]             storeLeft;
    logic [2:0]             loadLeft;
    logic [15:0]            pointer;
    logic [15:0]            dataPair;
    logic [8:0]             result;
    logic [3:0]             lockBits;
    phase_t                 phase;
    op_kind_t               opKind;
    logic [31:0]            opCount;
    logic                   opStalling;
    logic [WORDS-1:0]       bufValid;
    logic [15:0]            bufMem [WORDS];

    // ----------------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------------
    wire                    doWrite     = awHeld && wHeld && !s_axi_bvalid;
    wire                    doRead      = s_axi_arvalid && s_axi_arready;
    wire                    hitControl  = awAddr == `OFS_CONTROL;
    wire                    hitPointer  = awAddr == `OFS_POINTER;
    wire                    hitData     = awAddr == `OFS_DATA_PAIR;
    wire                    hitIssue    = awAddr == `OFS_ISSUE;
    wire                    wrMapped    = hitControl || hitPointer || hitData || hitIssue;
    wire                    opBusy      = phase == PHASE_RUN;
    wire                    selfprogEnable = opBusy || (armedCmd != `CMD_NONE);
    wire cmd_t              newCmd      = wData[4:0];
    wire                    legalCmd    = newCmd == `CMD_LOAD || newCmd == `CMD_ERASE
                                          || newCmd == `CMD_WRITE || newCmd == `CMD_LOCK
                                          || newCmd == `CMD_REENABLE;
    // Arming is refused while a program operation runs, so a re-enable can never act mid-operation.
    wire                    armCtl      = doWrite && hitControl && wStrb[0] && legalCmd
                                          && !selfprogEnable && !eepromWriteBusy;
    wire                    storeIssue  = doWrite && hitIssue && wStrb[0] && wData[`BIT_ISSUE_STORE]
                                          && storeLeft != 3'h0 && !eepromWriteBusy;
    wire                    loadIssue   = doWrite && hitIssue && wStrb[0] && wData[`BIT_ISSUE_LOAD]
                                          && !eepromWriteBusy;
    wire                    lockRead    = loadIssue && armedCmd == `CMD_LOCK && loadLeft != 3'h0;
    wire [WORD_BITS-1:0]    wordIdx     = pointer[WORD_BITS:1];
    wire [PAGE_BITS-1:0]    pageIdx     = pointer[WORD_BITS+PAGE_BITS:WORD_BITS+1];
    wire                    pageStalls  = 32'(pageIdx) >= STALL_FIRST;
    wire                    doLoadWord  = storeIssue && armedCmd == `CMD_LOAD && !bufValid[wordIdx];
    wire                    startErase  = storeIssue && armedCmd == `CMD_ERASE;
    wire                    startWrite  = storeIssue && armedCmd == `CMD_WRITE;
    wire                    startLock   = storeIssue && armedCmd == `CMD_LOCK;
    wire                    startOp     = startErase || startWrite || startLock;
    wire                    reEnable    = storeIssue && armedCmd == `CMD_REENABLE && !opBusy;
    wire                    opDone      = opBusy && opCount == 32'h0000_0001;
    wire                    bufClear    = (opDone && opKind == OP_WRITE) || reEnable
                                          || (eepromWriteBusy && armedCmd == `CMD_LOAD);
    wire [7:0]              lockByte    = {2'h3, lockBits, 2'h3};
    wire [7:0]              lockedByte  = (pointer == 16'h0001) ? lockByte
                                        : (pointer == 16'h0000) ? FUSE_LOW : 8'hff;
    wire [7:0]              ctrlRead    = {irqEnable, busyFlag, 1'b0, armedCmd[4:1], selfprogEnable};
    wire [3:0]              nextLocks   = lockBits & dataPair[`LOCK_LSB+3:`LOCK_LSB];

    logic [31:0]            readValue;
    logic                   readHit;
    always_comb begin
        readHit   = 1'b1;
        readValue = 32'h0000_0000;
        unique case (s_axi_araddr)
            `OFS_CONTROL:   readValue = {24'h00_0000, ctrlRead};
            `OFS_POINTER:   readValue = {16'h0000, pointer};
            `OFS_DATA_PAIR: readValue = {16'h0000, dataPair};
            `OFS_ISSUE:     readValue = 32'h0000_0000;
            `OFS_RESULT:    readValue = {23'h00_0000, result};
            `OFS_LOCKS:     readValue = {24'h00_0000, lockByte};
            `OFS_BUF_PEEK:  readValue = {15'h0000, bufValid[wordIdx], bufMem[wordIdx]};
            default:        readHit   = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------------
    // AXI4-Lite channels
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 8'h00;
            wData         <= 32'h0000_0000;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_OKAY;
        end else begin
            s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrMapped ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !doRead;
            if (doRead) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= readValue;
                s_axi_rresp  <= readHit ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pointer   <= 16'h0000;
            dataPair  <= 16'h0000;
            irqEnable <= 1'b0;
        end else begin
            if (doWrite && hitPointer) begin
                if (wStrb[0]) pointer[7:0]  <= wData[7:0];
                if (wStrb[1]) pointer[15:8] <= wData[15:8];
            end
            if (doWrite && hitData) begin
                if (wStrb[0]) dataPair[7:0]  <= wData[7:0];
                if (wStrb[1]) dataPair[15:8] <= wData[15:8];
            end
            if (doWrite && hitControl && wStrb[0]) begin
                irqEnable <= wData[`BIT_IRQ_EN];
            end
        end
    end

    // ----------------------------------------------------------------------
    // Command arming and timeouts
    // ----------------------------------------------------------------------
    // The store window counts four cycles and the load window three from the control write.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            armedCmd  <= `CMD_NONE;
            storeLeft <= 3'h0;
            loadLeft  <= 3'h0;
        end else if (armCtl) begin
            armedCmd  <= newCmd;
            storeLeft <= `STORE_WINDOW;
            loadLeft  <= `LOAD_WINDOW;
        end else if (storeIssue || lockRead || storeLeft == 3'h1) begin
            armedCmd  <= `CMD_NONE;
            storeLeft <= 3'h0;
            loadLeft  <= 3'h0;
        end else begin
            if (storeLeft != 3'h0) storeLeft <= storeLeft - 3'h1;
            if (loadLeft != 3'h0) loadLeft <= loadLeft - 3'h1;
        end
    end

    // ----------------------------------------------------------------------
    // Readback
    // ----------------------------------------------------------------------
    // Bit eight marks a lock or fuse answer; a plain load-program returns zero since no array is modelled.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            result <= 9'h000;
        end else if (lockRead) begin
            result <= {1'b1, lockedByte};
        end else if (loadIssue) begin
            result <= 9'h000;
        end
    end

    // ----------------------------------------------------------------------
    // Temporary page buffer
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bufValid <= '0;
        end else if (bufClear) begin
            bufValid <= '0;
        end else if (doLoadWord) begin
            bufValid[wordIdx] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (doLoadWord) begin
            bufMem[wordIdx] <= dataPair;
        end
    end

    // ----------------------------------------------------------------------
    // Program operation timer
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase      <= PHASE_IDLE;
            opKind     <= OP_ERASE;
            opCount    <= 32'h0000_0000;
            opStalling <= 1'b0;
            flashPage  <= '0;
        end else begin
            unique case (phase)
                PHASE_IDLE: begin
                    if (startOp) begin
                        phase      <= PHASE_RUN;
                        opCount    <= 32'(OP_CYCLES);
                        opKind     <= startErase ? OP_ERASE : startWrite ? OP_WRITE : OP_LOCK;
                        opStalling <= pageStalls && !startLock;
                        flashPage  <= pageIdx;
                    end
                end
                PHASE_RUN: begin
                    opCount <= opCount - 32'h0000_0001;
                    if (opDone) begin
                        phase      <= PHASE_IDLE;
                        opStalling <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lockBits <= `LOCKS_RESET;
        end else if (opDone && opKind == OP_LOCK) begin
            lockBits <= nextLocks;
        end
    end

    // ----------------------------------------------------------------------
    // Section status and outputs
    // ----------------------------------------------------------------------
    // A page load also releases the busy flag as a shortcut.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busyFlag <= 1'b0;
        end else if ((startErase || startWrite) && !pageStalls) begin
            busyFlag <= 1'b1;
        end else if (reEnable || doLoadWord) begin
            busyFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cpuHalt        <= 1'b0;
            sectionBlocked <= 1'b0;
            readyIrq       <= 1'b0;
            flashStart     <= 1'b0;
            flashOpKind    <= OP_ERASE;
        end else begin
            cpuHalt        <= (startOp && pageStalls && !startLock)
                              || (opBusy && opStalling && !opDone);
            sectionBlocked <= busyFlag || ((startErase || startWrite) && !pageStalls);
            readyIrq       <= irqEnable && !selfprogEnable;
            flashStart     <= startOp;
            flashOpKind    <= startErase ? OP_ERASE : startWrite ? OP_WRITE : startLock ? OP_LOCK : flashOpKind;
        end
    end

endmodule : flash_self_program_sequencer
